// ===== include/pdesp_pkg.sv
package pdesp_pkg;
  // ==================================================
  // register map (printed offsets, byte addresses)
  localparam logic [7:0] OFF_DATA_PINS   = 8'h08;
  localparam logic [7:0] OFF_DATA_DIR    = 8'h88;
  localparam logic [7:0] OFF_CTRL_PINS   = 8'h09;
  localparam logic [7:0] OFF_CTRL_STAT   = 8'h89;
  localparam logic [7:0] OFF_ANALOG_CFG  = 8'h9f;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'hc0;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'hc1;
  // ==================================================
  // field positions of the control/status register
  localparam int BIT_IBF  = 7;
  localparam int BIT_OBF  = 6;
  localparam int BIT_INPUT_OVERFLOW_FLAG = 5;
  localparam int BIT_MODE = 4;
  // ==================================================
  // reset values
  localparam logic [7:0] RST_DATA_DIR   = 8'hff;
  localparam logic [2:0] RST_CTRL_DIR   = 3'h7;
  localparam logic [3:0] RST_ANALOG_CFG = 4'h0;
  localparam logic [1:0] RST_IRQ_MASK   = 2'h0;
  // analog config values >= this make all control pins digital
  localparam logic [3:0] ANALOG_ALL_DIGITAL = 4'h6;
  // phase count: four quarter phases per instruction cycle
  localparam int PHASES = 4;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;
  // ==================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pdesp_bus_s;
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe_n;
  } pdesp_pins8_s;
endpackage

// ===== rtl/pdesp_sync3.sv
`timescale 1ns/100ps
module pdesp_sync3
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;
  // a change is accepted once the second and third stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      assign q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q[i];
    end
  endgenerate
  always_ff @(posedge clk)
  begin
    s1_reg <= d;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    if (!resetn)
      q <= rst_val;
    else
      q <= q_next;
  end
endmodule

// ===== rtl/pdesp_top.sv
`timescale 1ns/100ps
//Overview of operation
//- data pins are GPIO or slave bus bits
//- three control pins, each own direction
//- mode bit turns control pins into strobes
//- analog control pins read as zero
//- direction bits drive pins even analog
//- control pins come up analog after reset
//- output full until external read
//- overflow on unread write, software clears
//- data direction resets to all inputs
//- status register holds dirs, bit3 zero
//- write complete sets full on Q4 after Q2
//- input full cleared by CPU read only
//- slave mode ignores direction, two latches
module pdesp_top
(
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic [7:0]                  bus_addr,
  input  wire logic [7:0]                  bus_wdata,
  input  wire logic                        bus_wr,
  input  wire logic                        bus_rd,
  output logic      [7:0]                  bus_rdata,
  input  wire logic [7:0]                  data_pins_i,
  output pdesp_pkg::pdesp_pins8_s          data_pins,
  input  wire logic [2:0]                  ctrl_pins_i,
  output logic      [2:0]                  ctrl_pins_o,
  output logic      [2:0]                  ctrl_pins_oe_n,
  output logic                             slave_port_irq_flag,
  output logic                             irq
);
  import pdesp_pkg::*;
  // ==================================================
  // bus decode
  pdesp_bus_s bus;
  assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
  wire sel_dpin = bus.addr == OFF_DATA_PINS;
  wire sel_ddir = bus.addr == OFF_DATA_DIR;
  wire sel_cpin = bus.addr == OFF_CTRL_PINS;
  wire sel_stat = bus.addr == OFF_CTRL_STAT;
  wire sel_acfg = bus.addr == OFF_ANALOG_CFG;
  wire sel_ist  = bus.addr == OFF_IRQ_STATUS;
  wire sel_imsk = bus.addr == OFF_IRQ_MASK;
  // ==================================================
  // registers
  logic [7:0] out_latch_reg;
  logic [7:0] in_latch_reg;
  logic [7:0] ddir_reg;
  logic [2:0] cdir_reg;
  logic [2:0] cout_reg;
  logic       mode_reg;
  logic       ibf_reg;
  logic       obf_reg;
  logic       input_overflow_flag_reg;
  logic [3:0] acfg_reg;
  logic [1:0] ist_reg;
  logic [1:0] imsk_reg;
  logic [1:0] phase_reg;
  logic       pend_reg;
  logic       armed_reg;
  logic       seen_q2_reg;
  logic       rd_act_reg;
  logic [7:0] rdata_reg;
  // ==================================================
  // pin synchronisers
  logic [7:0] dpin_s;
  logic [2:0] cpin_s;
  pdesp_sync3 #(.W(8)) u_sync_d
  (
    .clk     (clk),
    .resetn  (resetn),
    .d       (data_pins_i),
    .rst_val (8'hff),
    .q       (dpin_s)
  );
  pdesp_sync3 #(.W(3)) u_sync_c
  (
    .clk     (clk),
    .resetn  (resetn),
    .d       (ctrl_pins_i),
    .rst_val (3'h7),
    .q       (cpin_s)
  );
  // ==================================================
  // control pin roles
  wire analog_n  = acfg_reg >= ANALOG_ALL_DIGITAL;
  wire ext_rd_n  = cpin_s[0];
  wire ext_wr_n  = cpin_s[1];
  wire ext_cs_n  = cpin_s[2];
  wire slave     = mode_reg;
  wire ext_wr_on = slave && !ext_cs_n && !ext_wr_n;
  wire ext_rd_on = slave && !ext_cs_n && !ext_rd_n;
  wire wr_end    = armed_reg && !ext_wr_on;
  wire rd_end    = rd_act_reg && !ext_rd_on;
  wire cpu_rd_in = bus.rd && sel_dpin && slave;
  wire cpu_wr_o  = bus.wr && sel_dpin;
  wire at_q2     = phase_reg == PH_Q2;
  wire at_q4     = phase_reg == PH_Q4;
  wire set_ibf   = pend_reg && seen_q2_reg && at_q4;
  // ==================================================
  // pin drivers
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_dpin
      assign data_pins.oe_n[g] = slave ? !ext_rd_on : ddir_reg[g];
    end
  endgenerate
  assign data_pins.o    = out_latch_reg;
  assign ctrl_pins_o    = cout_reg;
  assign ctrl_pins_oe_n = cdir_reg;
  // ==================================================
  // read mux
  wire [7:0] stat_val = {ibf_reg, obf_reg, input_overflow_flag_reg, mode_reg, 1'b0,
                         cdir_reg};
  wire [7:0] cpin_val = {5'h00, analog_n ? cpin_s : 3'h0};
  wire [7:0] dpin_val = slave ? in_latch_reg : dpin_s;
  wire [7:0] rd_mux =
    sel_dpin ? dpin_val :
    sel_ddir ? ddir_reg :
    sel_cpin ? cpin_val :
    sel_stat ? stat_val :
    sel_acfg ? {4'h0, acfg_reg} :
    sel_ist  ? {6'h00, ist_reg} :
    sel_imsk ? {6'h00, imsk_reg} : 8'h00;
  assign bus_rdata           = rdata_reg;
  assign slave_port_irq_flag = ist_reg[0];
  assign irq                 = |(ist_reg & imsk_reg);
  // ==================================================
  // next values
  wire ibf_next  = set_ibf || (ibf_reg && !cpu_rd_in);
  wire input_overflow_flag_set  = ext_wr_on && !armed_reg && ibf_reg;
  wire input_overflow_flag_next = input_overflow_flag_set ||
                   (input_overflow_flag_reg && !(bus.wr && sel_stat &&
                                  !bus.wdata[BIT_INPUT_OVERFLOW_FLAG]));
  wire obf_next  = (cpu_wr_o && slave) || (obf_reg && !rd_end);
  wire [1:0] ist_ev   = {input_overflow_flag_set, set_ibf};
  wire [1:0] ist_next = ist_ev |
                        (ist_reg & {2{!(bus.rd && sel_ist)}});
  wire q2_next = pend_reg && (seen_q2_reg || at_q2) && !set_ibf;
  // ==================================================
  // clocked state
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      out_latch_reg <= 8'h00;
      in_latch_reg  <= 8'h00;
      ddir_reg      <= RST_DATA_DIR;
      cdir_reg      <= RST_CTRL_DIR;
      cout_reg      <= 3'h0;
      mode_reg      <= 1'b0;
      ibf_reg       <= 1'b0;
      obf_reg       <= 1'b0;
      input_overflow_flag_reg      <= 1'b0;
      acfg_reg      <= RST_ANALOG_CFG;
      ist_reg       <= 2'h0;
      imsk_reg      <= RST_IRQ_MASK;
      phase_reg     <= 2'h0;
      pend_reg      <= 1'b0;
      armed_reg     <= 1'b0;
      seen_q2_reg   <= 1'b0;
      rd_act_reg    <= 1'b0;
      rdata_reg     <= 8'h00;
    end
    else
    begin
      phase_reg  <= phase_reg + 2'h1;
      armed_reg  <= ext_wr_on;
      rd_act_reg <= ext_rd_on;
      if (ext_wr_on)
        in_latch_reg <= dpin_s;
      pend_reg    <= wr_end || (pend_reg && !set_ibf);
      seen_q2_reg <= q2_next;
      ibf_reg     <= ibf_next;
      input_overflow_flag_reg    <= input_overflow_flag_next;
      obf_reg     <= obf_next;
      ist_reg     <= ist_next;
      rdata_reg   <= bus.rd ? rd_mux : 8'h00;
      if (cpu_wr_o)
        out_latch_reg <= bus.wdata;
      if (bus.wr && sel_ddir)
        ddir_reg <= bus.wdata;
      if (bus.wr && sel_cpin)
        cout_reg <= bus.wdata[2:0];
      if (bus.wr && sel_stat)
      begin
        mode_reg <= bus.wdata[BIT_MODE];
        cdir_reg <= bus.wdata[2:0];
      end
      if (bus.wr && sel_acfg)
        acfg_reg <= bus.wdata[3:0];
      if (bus.wr && sel_imsk)
        imsk_reg <= bus.wdata[1:0];
    end
  end
  // ==================================================
  // checks
  a_ibf_on_q4: assert property (@(posedge clk) disable iff (!resetn)
    $rose(ibf_reg) |-> $past(phase_reg) == PH_Q4)
    else $error("input full set off Q4");
  a_ibf_hold: assert property (@(posedge clk) disable iff (!resetn)
    ibf_reg && !cpu_rd_in |=> ibf_reg)
    else $error("input full cleared without read");
  a_input_overflow_flag_set: assert property (@(posedge clk) disable iff (!resetn)
    input_overflow_flag_set |=> input_overflow_flag_reg)
    else $error("overflow not set");
  a_obf_write: assert property (@(posedge clk) disable iff (!resetn)
    cpu_wr_o && slave |=> obf_reg)
    else $error("output full not set");
  a_drive_gate: assert property (@(posedge clk) disable iff (!resetn)
    slave && !ext_rd_on |-> &data_pins.oe_n)
    else $error("data driven without read");
  a_gpio_dir: assert property (@(posedge clk) disable iff (!resetn)
    !slave |-> data_pins.oe_n == ddir_reg)
    else $error("gpio direction wrong");
  a_analog_zero: assert property (@(posedge clk) disable iff (!resetn)
    bus.rd && sel_cpin && !analog_n |=> bus_rdata == 8'h00)
    else $error("analog pins not zero");
  a_bit3_zero: assert property (@(posedge clk) disable iff (!resetn)
    bus.rd && sel_stat |=> !bus_rdata[3])
    else $error("bit3 not zero");
  a_ibf_delay: assert property (@(posedge clk) disable iff (!resetn)
    wr_end |-> ##[1:8] ibf_reg)
    else $error("input full late");
  c_ext_write: cover property (@(posedge clk) $rose(ibf_reg));
  c_overflow: cover property (@(posedge clk) $rose(input_overflow_flag_reg));
  c_ext_read: cover property (@(posedge clk) rd_end && obf_reg);
  c_irq: cover property (@(posedge clk) $rose(irq));
endmodule

// ===== tb/pdesp_ext_cpu.sv
`timescale 1ns/100ps
module pdesp_ext_cpu
(
  input  wire logic       clk,
  input  wire logic [7:0] bus,
  output logic      [2:0] strobe_n,
  output logic      [7:0] d
);
  initial
  begin
    strobe_n = 3'h7;
    d        = 8'h00;
  end
  // ====================
  // one external transfer: wr 1 writes v, wr 0 reads into got
  task automatic xfer(input logic wr, input logic [7:0] v,
                      output logic [7:0] got);
    @(posedge clk);
    d        <= v;
    strobe_n <= wr ? 3'h1 : 3'h2;
    repeat (8) @(posedge clk);
    got = bus;
    strobe_n <= 3'h7;
    @(posedge clk);
    d <= ~v; // released bus must not keep the old byte
  endtask
endmodule

// ===== tb/test_port_d_e_slave_port_ctrl.sv
`timescale 1ns/100ps
`define CHK(a, e) \
  begin \
    tests_run++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("wrong value at %0t: got %h want %h", $time, a, e); \
    end \
  end
module test_port_d_e_slave_port_ctrl;
  import pdesp_pkg::*;
  logic         clk, resetn, bus_wr, bus_rd, rd_q, irq, slave_port_irq_flag;
  logic   [7:0] bus_addr, bus_wdata, bus_rdata, ext_d, got, b1, b2, e_v;
  logic   [2:0] ctrl_pins_o, ctrl_pins_oe_n, strobe_n;
  pdesp_pins8_s data_pins;
  int           failures, tests_run;
  logic   [7:0] exp_q[$];
  wire    [7:0] pins = (data_pins.o & ~data_pins.oe_n)
                       | (ext_d & data_pins.oe_n);
  wire    [2:0] cpins = (ctrl_pins_o & ~ctrl_pins_oe_n)
                        | (strobe_n & ctrl_pins_oe_n);
  pdesp_top dut_u (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .data_pins_i(pins), .data_pins(data_pins),
    .ctrl_pins_i(cpins), .ctrl_pins_o(ctrl_pins_o),
    .ctrl_pins_oe_n(ctrl_pins_oe_n),
    .slave_port_irq_flag(slave_port_irq_flag), .irq(irq));
  pdesp_ext_cpu ext_u (.clk(clk), .bus(pins), .strobe_n(strobe_n), .d(ext_d));
  // ====================
  // bus tasks and read-data monitor
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= v;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    bus_rd <= 1'b0;
  endtask
  task automatic wait_flag;
    for (int i = 0; i < 40 && slave_port_irq_flag !== 1'b1; i++)
      @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (rd_q === 1'b1)
    begin
      e_v = exp_q.pop_front();
      `CHK(bus_rdata, e_v)
    end
    rd_q <= bus_rd;
  end
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #25000;
    failures++;
    wrap_up();
  end
  // ====================
  // main sequence
  initial
  begin
    {bus_addr, bus_wdata, bus_wr, bus_rd, rd_q, resetn} = '0;
    void'($urandom(28));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    `CHK(data_pins.oe_n, 8'hff)
    `CHK(ctrl_pins_oe_n, 3'h7)
    rd(OFF_DATA_DIR, 8'hff);
    rd(OFF_CTRL_STAT, 8'h07);
    rd(OFF_CTRL_PINS, 8'h00);
    rd(8'h55, 8'h00);
    $display("test reset done");
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    wr(OFF_DATA_DIR, b1);
    wr(OFF_DATA_PINS, b2);
    wr(OFF_CTRL_STAT, 8'h05);
    wr(OFF_CTRL_PINS, {5'h00, b2[2:0]});
    repeat (5) @(posedge clk);
    `CHK(ctrl_pins_o, b2[2:0])
    `CHK(data_pins.oe_n, b1)
    `CHK(data_pins.o, b2)
    `CHK(ctrl_pins_oe_n, 3'h5)
    rd(OFF_DATA_PINS, (b2 & ~b1) | (ext_d & b1));
    rd(OFF_CTRL_PINS, 8'h00);
    wr(OFF_ANALOG_CFG, {4'h0, ANALOG_ALL_DIGITAL});
    repeat (5) @(posedge clk);
    rd(OFF_CTRL_PINS, {5'h00, 1'b1, b2[1], 1'b1});
    $display("test general io done");
    wr(OFF_IRQ_MASK, 8'h03);
    wr(OFF_DATA_DIR, 8'h00);
    wr(OFF_CTRL_STAT, 8'h17);
    repeat (5) @(posedge clk);
    `CHK(data_pins.oe_n, 8'hff)
    ext_u.xfer(1'b1, b1, got);
    wait_flag();
    `CHK(slave_port_irq_flag, 1'b1)
    `CHK(irq, 1'b1)
    rd(OFF_CTRL_STAT, 8'h97);
    rd(OFF_IRQ_STATUS, 8'h01);
    #1;
    `CHK(irq, 1'b0)
    ext_u.xfer(1'b1, b2, got);
    wait_flag();
    rd(OFF_IRQ_STATUS, 8'h03);
    wr(OFF_CTRL_STAT, 8'hf7);
    rd(OFF_CTRL_STAT, 8'hb7);
    wr(OFF_CTRL_STAT, 8'h17);
    rd(OFF_CTRL_STAT, 8'h97);
    rd(OFF_DATA_PINS, b2);
    rd(OFF_CTRL_STAT, 8'h17);
    $display("test slave write done");
    wr(OFF_DATA_PINS, b1);
    rd(OFF_CTRL_STAT, 8'h57);
    ext_u.xfer(1'b0, 8'h00, got);
    `CHK(got, b1)
    repeat (6) @(posedge clk);
    `CHK(data_pins.oe_n, 8'hff)
    rd(OFF_CTRL_STAT, 8'h17);
    wr(OFF_CTRL_STAT, 8'h07);
    repeat (5) @(posedge clk);
    `CHK(data_pins.oe_n, 8'h00)
    $display("test slave read done");
    wrap_up();
  end
endmodule
